/* core/nfh_pkg.sv */
// Package with commands, timing counts, status layout and carrier types for the NAND host.
package nfh_pkg;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned T_PHASE_NS = 25;
  localparam int unsigned T_PHASE_CYC = (T_PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned T_WB_NS = 100;
  localparam int unsigned T_WB_CYC = (T_WB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic [7:0] CMD_READ_SETUP = 8'h00;
  localparam logic [7:0] CMD_READ_START = 8'h30;
  localparam logic [7:0] CMD_CACHE_NEXT = 8'h31;
  localparam logic [7:0] CMD_CACHE_LAST = 8'h3F;
  localparam logic [7:0] CMD_READ_ID = 8'h90;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] CMD_RESET = 8'hFF;
  localparam logic [7:0] ID_ADDR_MAKER = 8'h00;
  localparam logic [7:0] ID_ADDR_SIG = 8'h20;

  localparam int unsigned ST_PASS_BIT = 0;
  localparam int unsigned ST_OTP_BIT = 2;
  localparam int unsigned ST_TRUE_RDY_BIT = 5;
  localparam int unsigned ST_RDY_BIT = 6;
  localparam int unsigned ST_WP_BIT = 7;
  localparam logic [7:0] ST_MASK_PLAIN = 8'hC0;
  localparam logic [7:0] ST_MASK_CACHE = 8'hE0;

  localparam int unsigned PAGE_BITS = 6;
  localparam logic [5:0] PAGE_LAST = 6'h3F;
  localparam logic [1:0] ADDR_LAST = 2'h3;

  typedef enum logic [2:0] {
    OP_STATUS = 3'h0,
    OP_READ_ID = 3'h1,
    OP_RESET = 3'h2,
    OP_PAGE_READ = 3'h3,
    OP_CACHE_NEXT = 3'h4,
    OP_CACHE_LAST = 3'h5,
    OP_READ_MODE = 3'h6
  } nfh_op_t;

  typedef struct packed {
    nfh_op_t op;
    logic id_sig;
    logic [15:0] col;
    logic [15:0] row;
    logic [11:0] len;
  } nfh_req_t;

  typedef struct packed {
    logic ce_n;
    logic cle;
    logic ale;
    logic we_n;
    logic read_strobe_n;
    logic wp_n;
  } nfh_pins_t;

  localparam nfh_pins_t PINS_IDLE = 6'b1_0_0_1_1_0;
endpackage

/* core/nfh_fifo.sv */
// Synchronous FIFO with valid/ready on both sides for the read data path.
`timescale 1ns/1ps
module nfh_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW:0] wr_ptr_ff;
  logic [AW:0] rd_ptr_ff;
  logic full;
  logic empty;

  assign empty = (wr_ptr_ff == rd_ptr_ff);
  assign full = (wr_ptr_ff[AW] != rd_ptr_ff[AW]) && (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem_ff[rd_ptr_ff[AW-1:0]];

  always_ff @(posedge sys_clk) begin
    if (in_valid && !full) begin
      mem_ff[wr_ptr_ff[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
    end else begin
      if (in_valid && !full) begin
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (out_ready && !empty) begin
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      end
    end
  end
endmodule

/* core/nfh_host.sv */
// Host controller that drives a NAND flash device through its command, address and data pins.
`timescale 1ns/1ps
//Contract
// - Host masks undefined status bits.
// - Identification: command 90h then address 00h.
// - Page read precedes cache read; one block.
// - 3Fh finishes cache read with last transfer.
// - During power-up busy, only status command.
// - Write-protect held high through program/erase.
// - Status mode holds; 00h resumes data output.
module nfh_host
  import nfh_pkg::*;
#(
  parameter int unsigned FIFO_DEPTH = 16
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic req_valid,
  output logic req_ready,
  input wire nfh_req_t req,
  output logic req_err,
  output logic done,
  input wire logic wp_release,
  output logic [7:0] status_byte,
  output logic status_valid,
  output logic [7:0] rd_data,
  output logic rd_valid,
  input wire logic rd_ready,
  output nfh_pins_t pins,
  output logic [7:0] dq_out,
  output logic dq_oe,
  input wire logic [7:0] dq_in,
  input wire logic rb_in,
  output logic dev_busy,
  output logic init_busy
);
  typedef enum logic [6:0] {
    S_IDLE = 7'b0000001,
    S_CMD1 = 7'b0000010,
    S_ADDR = 7'b0000100,
    S_CMD2 = 7'b0001000,
    S_WB = 7'b0010000,
    S_RB = 7'b0100000,
    S_READ = 7'b1000000
  } nfh_state_t;

  nfh_state_t state_ff;
  nfh_req_t op_ff;
  nfh_pins_t pins_ff;
  logic [7:0] dq_out_ff;
  logic dq_oe_ff;
  logic [7:0] tmr_ff;
  logic phase_ff;
  logic [1:0] addr_idx_ff;
  logic [11:0] cnt_ff;
  logic [7:0] dq_s1_ff;
  logic [7:0] dq_s2_ff;
  logic rb_s1_ff;
  logic rb_s2_ff;
  logic init_ff;
  logic [7:0] pwr_tmr_ff;
  logic page_valid_ff;
  logic [PAGE_BITS-1:0] page_ff;
  logic cache_mode_ff;
  logic [7:0] status_ff;
  logic status_valid_ff;
  logic done_ff;
  logic err_ff;
  logic push_ff;
  logic [7:0] push_data_ff;
  logic fifo_in_ready;
  logic accept;
  logic req_ok;
  logic phase_end;

  function automatic logic [7:0] first_cmd(input nfh_op_t op);
    unique case (op)
      OP_STATUS: first_cmd = CMD_STATUS;
      OP_READ_ID: first_cmd = CMD_READ_ID;
      OP_RESET: first_cmd = CMD_RESET;
      OP_CACHE_NEXT: first_cmd = CMD_CACHE_NEXT;
      OP_CACHE_LAST: first_cmd = CMD_CACHE_LAST;
      default: first_cmd = CMD_READ_SETUP;
    endcase
  endfunction

  function automatic logic [7:0] addr_byte(input nfh_req_t r, input logic [1:0] idx);
    unique case (idx)
      2'h0: addr_byte = r.col[7:0];
      2'h1: addr_byte = r.col[15:8];
      2'h2: addr_byte = r.row[7:0];
      default: addr_byte = r.row[15:8];
    endcase
  endfunction

  assign dev_busy = !rb_s2_ff;
  assign init_busy = init_ff;
  assign req_ready = (state_ff == S_IDLE);
  assign accept = req_valid && req_ready;
  assign phase_end = (tmr_ff == 8'(T_PHASE_CYC - 1));
  assign pins = pins_ff;
  assign dq_out = dq_out_ff;
  assign dq_oe = dq_oe_ff;
  assign status_byte = status_ff;
  assign status_valid = status_valid_ff;
  assign done = done_ff;
  assign req_err = err_ff;

  // Busy devices take only status and reset; power-up takes status alone; cache reads stay in one block.
  always_comb begin
    req_ok = 1'b1;
    if (init_ff) begin
      req_ok = (req.op == OP_STATUS);
    end else if (dev_busy) begin
      req_ok = (req.op == OP_STATUS) || (req.op == OP_RESET);
    end else if (req.op == OP_CACHE_NEXT) begin
      req_ok = page_valid_ff && (page_ff != PAGE_LAST);
    end else if (req.op == OP_CACHE_LAST) begin
      req_ok = page_valid_ff;
    end
  end

  // The ready/busy net is open-drain with an outside pull-up; both it and the data bus are synchronised.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rb_s1_ff <= 1'b0;
      rb_s2_ff <= 1'b0;
      dq_s1_ff <= 8'h00;
      dq_s2_ff <= 8'h00;
    end else begin
      rb_s1_ff <= rb_in;
      rb_s2_ff <= rb_s1_ff;
      dq_s1_ff <= dq_in;
      dq_s2_ff <= dq_s1_ff;
    end
  end

  // Power-up initialisation ends on the first ready seen with the sequencer idle after the settling wait.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      init_ff <= 1'b1;
      pwr_tmr_ff <= 8'h00;
    end else if (init_ff) begin
      if (pwr_tmr_ff != 8'(T_WB_CYC)) begin
        pwr_tmr_ff <= pwr_tmr_ff + 8'h01;
      end else if (rb_s2_ff && state_ff == S_IDLE) begin
        init_ff <= 1'b0;
      end
    end
  end

  // Page tracking for cache reads and the status mask for the current operation.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      page_valid_ff <= 1'b0;
      page_ff <= '0;
      cache_mode_ff <= 1'b0;
    end else if (accept && req_ok) begin
      unique case (req.op)
        OP_PAGE_READ: begin
          page_valid_ff <= 1'b1;
          page_ff <= req.row[PAGE_BITS-1:0];
          cache_mode_ff <= 1'b0;
        end
        OP_CACHE_NEXT: begin
          page_ff <= page_ff + 1'b1;
          cache_mode_ff <= 1'b1;
        end
        OP_CACHE_LAST: begin
          page_valid_ff <= 1'b0;
        end
        OP_RESET, OP_READ_ID: begin
          page_valid_ff <= 1'b0;
          cache_mode_ff <= 1'b0;
        end
        default: begin
        end
      endcase
    end
  end

  // Write-protect only changes while the device is idle and ready.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pins_ff.wp_n <= 1'b0;
    end else if (state_ff == S_IDLE && !dev_busy && !init_ff) begin
      pins_ff.wp_n <= wp_release;
    end
  end

  // Sequencer: command, address, confirm, busy wait, then read cycles.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_ff <= S_IDLE;
      op_ff <= '0;
      {pins_ff.ce_n, pins_ff.cle, pins_ff.ale, pins_ff.we_n, pins_ff.read_strobe_n} <= PINS_IDLE[5:1];
      dq_out_ff <= 8'h00;
      dq_oe_ff <= 1'b0;
      tmr_ff <= 8'h00;
      phase_ff <= 1'b0;
      addr_idx_ff <= 2'h0;
      cnt_ff <= 12'h000;
      done_ff <= 1'b0;
      err_ff <= 1'b0;
      push_ff <= 1'b0;
      push_data_ff <= 8'h00;
      status_ff <= 8'h00;
      status_valid_ff <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      err_ff <= 1'b0;
      push_ff <= 1'b0;
      status_valid_ff <= 1'b0;
      unique case (state_ff)
        S_IDLE: begin
          pins_ff.ce_n <= 1'b1;
          if (accept && !req_ok) begin
            err_ff <= 1'b1;
          end else if (accept) begin
            op_ff <= req;
            cnt_ff <= (req.op == OP_STATUS) ? 12'h001 : req.len;
            dq_out_ff <= first_cmd(req.op);
            dq_oe_ff <= 1'b1;
            pins_ff.ce_n <= 1'b0;
            pins_ff.cle <= 1'b1;
            pins_ff.we_n <= 1'b0;
            tmr_ff <= 8'h00;
            phase_ff <= 1'b0;
            addr_idx_ff <= 2'h0;
            state_ff <= S_CMD1;
          end
        end
        S_CMD1, S_ADDR, S_CMD2: begin
          tmr_ff <= tmr_ff + 8'h01;
          if (phase_end && !phase_ff) begin
            pins_ff.we_n <= 1'b1;
            tmr_ff <= 8'h00;
            phase_ff <= 1'b1;
          end else if (phase_end) begin
            tmr_ff <= 8'h00;
            phase_ff <= 1'b0;
            pins_ff.cle <= 1'b0;
            pins_ff.ale <= 1'b0;
            dq_oe_ff <= 1'b0;
            if (state_ff == S_CMD1 && (op_ff.op == OP_READ_ID || op_ff.op == OP_PAGE_READ)) begin
              pins_ff.ale <= 1'b1;
              pins_ff.we_n <= 1'b0;
              dq_oe_ff <= 1'b1;
              dq_out_ff <= (op_ff.op == OP_READ_ID) ?
                (op_ff.id_sig ? ID_ADDR_SIG : ID_ADDR_MAKER) : addr_byte(op_ff, 2'h0);
              state_ff <= S_ADDR;
            end else if (state_ff == S_ADDR && op_ff.op == OP_PAGE_READ && addr_idx_ff != ADDR_LAST) begin
              pins_ff.ale <= 1'b1;
              pins_ff.we_n <= 1'b0;
              dq_oe_ff <= 1'b1;
              dq_out_ff <= addr_byte(op_ff, addr_idx_ff + 2'h1);
              addr_idx_ff <= addr_idx_ff + 2'h1;
            end else if (state_ff == S_ADDR && op_ff.op == OP_PAGE_READ) begin
              pins_ff.cle <= 1'b1;
              pins_ff.we_n <= 1'b0;
              dq_oe_ff <= 1'b1;
              dq_out_ff <= CMD_READ_START;
              state_ff <= S_CMD2;
            end else if (op_ff.op == OP_STATUS || op_ff.op == OP_READ_MODE || op_ff.op == OP_READ_ID) begin
              state_ff <= S_READ;
            end else begin
              state_ff <= S_WB;
            end
          end
        end
        S_WB: begin
          tmr_ff <= tmr_ff + 8'h01;
          if (tmr_ff == 8'(T_WB_CYC - 1)) begin
            tmr_ff <= 8'h00;
            state_ff <= S_RB;
          end
        end
        S_RB: begin
          if (rb_s2_ff) begin
            state_ff <= (op_ff.op == OP_RESET) ? S_IDLE : S_READ;
            done_ff <= (op_ff.op == OP_RESET);
          end
        end
        S_READ: begin
          if (!pins_ff.read_strobe_n) begin
            tmr_ff <= tmr_ff + 8'h01;
            if (phase_end) begin
              pins_ff.read_strobe_n <= 1'b1;
              tmr_ff <= 8'h00;
              cnt_ff <= cnt_ff - 12'h001;
              if (op_ff.op == OP_STATUS) begin
                status_ff <= dq_s2_ff & (cache_mode_ff ? ST_MASK_CACHE : ST_MASK_PLAIN);
                status_valid_ff <= 1'b1;
              end else begin
                push_ff <= 1'b1;
                push_data_ff <= dq_s2_ff;
              end
            end
          end else if (!phase_end) begin
            tmr_ff <= tmr_ff + 8'h01;
          end else if (cnt_ff == 12'h000) begin
            done_ff <= 1'b1;
            tmr_ff <= 8'h00;
            state_ff <= S_IDLE;
          end else if (op_ff.op == OP_STATUS || (fifo_in_ready && !push_ff)) begin
            pins_ff.read_strobe_n <= 1'b0;
            tmr_ff <= 8'h00;
          end
        end
      endcase
    end
  end

  nfh_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .sys_clk(sys_clk),
    .rst(rst),
    .in_valid(push_ff),
    .in_ready(fifo_in_ready),
    .in_data(push_data_ff),
    .out_valid(rd_valid),
    .out_ready(rd_ready),
    .out_data(rd_data)
  );

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  status_mask_a: assert property (status_valid |-> status_byte[4:0] == 5'h00)
    else $error("undefined status bits not masked");
  id_addr_a: assert property (state_ff == S_ADDR && op_ff.op == OP_READ_ID && !pins_ff.we_n |->
    pins_ff.ale && dq_oe_ff && (dq_out_ff == ID_ADDR_MAKER || dq_out_ff == ID_ADDR_SIG))
    else $error("bad identification address cycle");
  id_cmd_a: assert property ($rose(state_ff == S_CMD1) && op_ff.op == OP_READ_ID |->
    dq_out_ff == CMD_READ_ID && pins_ff.cle && !pins_ff.we_n)
    else $error("identification command not 90h");
  cache_guard_a: assert property (accept && req.op == OP_CACHE_NEXT && !page_valid_ff && !init_ff |=>
    req_err && state_ff == S_IDLE)
    else $error("cache read accepted without page read");
  cache_last_a: assert property ($rose(state_ff == S_CMD1) && op_ff.op == OP_CACHE_LAST |->
    dq_out_ff == CMD_CACHE_LAST)
    else $error("cache finish command not 3Fh");
  init_status_a: assert property (init_ff && $rose(state_ff == S_CMD1) |-> dq_out_ff == CMD_STATUS)
    else $error("non-status command during power-up");
  wp_hold_a: assert property (dev_busy ##1 dev_busy |-> $stable(pins_ff.wp_n))
    else $error("write-protect changed while busy");
  resume_a: assert property ($rose(state_ff == S_CMD1) && op_ff.op == OP_READ_MODE |->
    dq_out_ff == CMD_READ_SETUP ##1 pins_ff.cle)
    else $error("resume command not 00h");
  we_width_a: assert property ($fell(pins_ff.we_n) |-> !pins_ff.we_n [*3] ##1 pins_ff.we_n)
    else $error("write strobe width wrong");
  strobe_excl_a: assert property (!(!pins_ff.we_n && !pins_ff.read_strobe_n))
    else $error("read and write strobes low together");

  id_read_c: cover property (done && op_ff.op == OP_READ_ID);
  cache_read_c: cover property (done && op_ff.op == OP_CACHE_NEXT);
  status_c: cover property (status_valid && status_byte[ST_RDY_BIT]);
  fifo_full_c: cover property (state_ff == S_READ && !fifo_in_ready);
endmodule

/* bench/nfh_dev_model.sv */
// Behavioural NAND device that answers the host's command, address and read strobes.
`timescale 1ns/1ps
module nfh_dev_model
  import nfh_pkg::*;
#(
  parameter logic [39:0] ID_CODES = 40'h1122334455,
  parameter logic [31:0] SIG_CODES = 32'hA1B2C3D4
) (
  input wire nfh_pins_t pins,
  input wire logic [7:0] dq_host,
  input wire logic slow,
  output logic [7:0] dq_dev,
  output logic rb_low
);
  // The identification and signature defaults are arbitrary values.
  logic [7:0] cur = 8'h00;
  logic [7:0] adr [0:3];
  logic [15:0] dp = 16'h0000;
  logic [15:0] op = 16'h0000;
  logic [15:0] col = 16'h0000;
  logic [1:0] md = 2'h0;
  logic sig = 1'b0;
  logic busy;
  logic arr;
  int na = 0;
  int ix = 0;
  realtime bt = 300;
  realtime bend = 600;
  realtime aend = 0;

  function automatic logic [7:0] pat(input logic [15:0] p, input logic [15:0] c);
    return 8'(p * 7 + c);
  endfunction

  always begin
    busy = $realtime < bend;
    arr = $realtime < aend;
    #5;
  end

  // The pin only ever pulls low; the pull-up lives on the net.
  assign rb_low = busy;

  always @(posedge pins.we_n) begin
    bt = slow ? 3000 : 300;
    if (!pins.ce_n && pins.cle) begin
      case (dq_host)
        CMD_STATUS: md = 2'h1;
        CMD_READ_SETUP: begin
          md = 2'h0;
          na = 0;
        end
        CMD_READ_ID: begin
          md = 2'h2;
          na = 0;
        end
        CMD_READ_START: begin
          dp = {adr[3], adr[2]};
          op = dp;
          col = {adr[1], adr[0]};
          bend = $realtime + bt;
        end
        CMD_CACHE_NEXT: begin
          op = dp;
          dp = dp + 16'h0001;
          col = 16'h0000;
          bend = $realtime + 150;
          aend = $realtime + bt;
        end
        CMD_CACHE_LAST: begin
          op = dp;
          col = 16'h0000;
          bend = $realtime + bt;
          aend = bend;
        end
        CMD_RESET: begin
          md = 2'h3;
          aend = 0;
          bend = $realtime + bt;
        end
        default: ;
      endcase
    end else if (!pins.ce_n && pins.ale && na < 4) begin
      adr[na] = dq_host;
      na = na + 1;
      sig = (dq_host == ID_ADDR_SIG);
      ix = 0;
    end
  end

  always @(negedge pins.read_strobe_n) begin
    if (!pins.ce_n) begin
      case (md)
        2'h0: begin
          cur = pat(op, col);
          col = col + 16'h0001;
        end
        2'h1: cur = {pins.wp_n, !busy, !arr, 5'h00};
        2'h2: begin
          cur = sig ? SIG_CODES[31 - 8 * (ix % 4) -: 8] : ID_CODES[39 - 8 * (ix % 5) -: 8];
          ix = ix + 1;
        end
        default: cur = ~cur;
      endcase
    end
  end

  // A released bus shows the inverse of the last byte, never a stale copy.
  assign dq_dev = (!pins.ce_n && !pins.read_strobe_n) ? cur : ~cur;
endmodule

/* bench/test_nand_status_id_reset_cache_read.sv */
// Self-checking bench for the NAND host controller against a behavioural device.
`timescale 1ns/1ps
module test_nand_status_id_reset_cache_read
  import nfh_pkg::*;
;
  localparam logic [39:0] ID_CODES = 40'h1122334455;
  localparam logic [31:0] SIG_CODES = 32'hA1B2C3D4;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic req_valid = 1'b0;
  logic wp_release = 1'b0;
  logic rd_ready = 1'b0;
  logic slow = 1'b0;
  logic stall = 1'b0;
  logic was_err = 1'b0;
  logic saw_busy = 1'b0;
  logic saw_stat = 1'b0;
  nfh_req_t req = '0;
  logic req_ready, req_err, done, status_valid, rd_valid, dq_oe, dev_busy, init_busy, rb_low;
  logic [7:0] status_byte, rd_data, dq_out, dq_dev, dq_bus;
  nfh_pins_t pins;
  int err_total = 0;
  int checked = 0;
  logic [7:0] got [$];

  assign dq_bus = dq_oe ? dq_out : dq_dev;

  nfh_host #(.FIFO_DEPTH(16)) uut (.sys_clk(sys_clk), .rst(rst), .req_valid(req_valid), .req_ready(req_ready),
    .req(req), .req_err(req_err), .done(done), .wp_release(wp_release), .status_byte(status_byte),
    .status_valid(status_valid), .rd_data(rd_data), .rd_valid(rd_valid), .rd_ready(rd_ready), .pins(pins),
    .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_bus), .rb_in(!rb_low), .dev_busy(dev_busy), .init_busy(init_busy));

  nfh_dev_model #(.ID_CODES(ID_CODES), .SIG_CODES(SIG_CODES)) dev (.pins(pins), .dq_host(dq_bus), .slow(slow),
    .dq_dev(dq_dev), .rb_low(rb_low));

  initial begin
    forever #5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    if (rd_valid && rd_ready) begin
      got.push_back(rd_data);
    end
    if (dev_busy) begin
      saw_busy = 1'b1;
    end
    if (status_valid) begin
      saw_stat = 1'b1;
    end
  end

  always @(negedge sys_clk) begin
    rd_ready <= !stall && ($urandom % 4 != 0);
  end

  function automatic logic [7:0] pat(input logic [15:0] p, input logic [15:0] c);
    return 8'(p * 7 + c);
  endfunction

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic tally_and_finish();
    if (err_total == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic run(input nfh_op_t o, input logic s, input logic [15:0] c, input logic [15:0] r,
                     input logic [11:0] n);
    int k;
    got.delete();
    saw_busy = 1'b0;
    saw_stat = 1'b0;
    k = 0;
    @(negedge sys_clk);
    while (!req_ready && k < 20000) begin
      @(negedge sys_clk);
      k++;
    end
    req_valid = 1'b1;
    req = '{o, s, c, r, n};
    @(negedge sys_clk);
    req_valid = 1'b0;
    while (!done && !req_err && k < 20000) begin
      @(negedge sys_clk);
      k++;
      if (k == 600) begin
        stall = 1'b0;
      end
    end
    was_err = req_err;
    // A status byte lands in status_byte, never in the read queue.
    while (o != OP_STATUS && got.size() < n && !was_err && k < 20000) begin
      @(negedge sys_clk);
      k++;
    end
    // A hung operation counts as a mismatch.
    if (k >= 20000) begin
      chk(8'h00, 8'h01);
    end
  endtask

  task automatic chk_data(input logic [15:0] p, input logic [15:0] c, input int n);
    chk(8'(got.size()), 8'(n));
    for (int i = 0; i < n && i < got.size(); i++) begin
      chk(got[i], pat(p, 16'(c + i)));
    end
  endtask

  initial begin
    logic [15:0] r;
    logic [15:0] c;
    int n;
    int m;
    void'($urandom(62));
    repeat (20) @(negedge sys_clk);
    rst = 1'b0;
    run(OP_STATUS, 1'b0, 16'h0000, 16'h0000, 12'h001);
    chk(status_byte, 8'h00);
    chk(8'(saw_stat), 8'h01);
    run(OP_PAGE_READ, 1'b0, 16'h0000, 16'h0005, 12'h004);
    chk(8'(was_err), 8'h01);
    for (int k = 0; k < 1000 && init_busy; k++) begin
      @(negedge sys_clk);
    end
    chk(8'(init_busy), 8'h00);
    run(OP_READ_MODE, 1'b0, 16'h0000, 16'h0000, 12'h003);
    chk_data(16'h0000, 16'h0000, 3);
    for (int s = 0; s < 2; s++) begin
      run(OP_READ_ID, s[0], 16'h0000, 16'h0000, 12'(5 - s));
      chk(8'(got.size()), 8'(5 - s));
      for (int i = 0; i < 5 - s; i++) begin
        chk(got[i], s ? SIG_CODES[31 - 8 * i -: 8] : ID_CODES[39 - 8 * i -: 8]);
      end
    end
    for (int w = 0; w < 2; w++) begin
      wp_release = w[0];
      run(OP_STATUS, 1'b0, 16'h0000, 16'h0000, 12'h001);
      chk(status_byte, w ? 8'hC0 : 8'h40);
    end
    run(OP_CACHE_NEXT, 1'b0, 16'h0000, 16'h0000, 12'h002);
    chk(8'(was_err), 8'h01);
    for (int t = 0; t < 6; t++) begin
      r = (16'($urandom) & 16'hFFC0) | 16'($urandom % 61);
      c = 16'($urandom % 2048);
      n = t == 0 ? 40 : 1 + $urandom % 20;
      m = $urandom % 3;
      slow = 1'($urandom % 2);
      stall = t == 0;
      run(OP_PAGE_READ, 1'b0, c, r, 12'(n));
      chk_data(r, c, n);
      for (int i = 0; i < m; i++) begin
        run(OP_CACHE_NEXT, 1'b0, 16'h0000, 16'h0000, 12'(n));
        chk_data(16'(r + i), 16'h0000, n);
      end
      run(OP_CACHE_LAST, 1'b0, 16'h0000, 16'h0000, 12'(n));
      chk_data(16'(r + m), 16'h0000, n);
      run(OP_STATUS, 1'b0, 16'h0000, 16'h0000, 12'h001);
      chk(status_byte, m > 0 ? 8'hE0 : 8'hC0);
    end
    run(OP_PAGE_READ, 1'b0, 16'h0000, 16'h013F, 12'h002);
    run(OP_CACHE_NEXT, 1'b0, 16'h0000, 16'h0000, 12'h002);
    chk(8'(was_err), 8'h01);
    slow = 1'b1;
    run(OP_RESET, 1'b0, 16'h0000, 16'h0000, 12'h000);
    chk(8'(saw_busy), 8'h01);
    chk(8'(was_err), 8'h00);
    run(OP_STATUS, 1'b0, 16'h0000, 16'h0000, 12'h001);
    chk(status_byte, 8'hC0);
    tally_and_finish();
  end

  initial begin
    #600000;
    err_total++;
    tally_and_finish();
  end
endmodule
